/* File: logic/nv_host_ctrl.sv */
/*
  CPU-side controller: an AXI4-Lite slave holds commands that it replays
  as timed I/O sequences on the EEPROM device bus. Assumes the device
  answers io reads one cycle later and raises cpu_stall as it takes work.
*/
`timescale 1ns/10ps
`default_nettype none
module nv_host_ctrl
  import nv_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic irq,
  nv_io_if.cpu io
);
  host_state_t state;
  host_op_t op;
  logic [2:0] step;
  logic [ADDR_W-1:0] cmd_addr;
  logic [7:0] cmd_data;
  logic [7:0] result;
  logic [2:0] cfg;
  logic [2:0] irq_status;
  logic [2:0] irq_mask;
  logic [7:0] aw_q;
  logic [31:0] w_q;
  logic aw_held;
  logic w_held;
  logic ready_seen;
  logic [5:0] plan_addr;
  logic [7:0] plan_wdata;
  logic plan_rd;
  logic plan_last;

  wire do_write = aw_held && w_held && !bvalid;
  wire hit_w = aw_q == REG_CMD_ADDR || aw_q == REG_CMD_DATA
      || aw_q == REG_CMD_GO || aw_q == REG_CONFIG
      || aw_q == REG_IRQ_STATUS || aw_q == REG_IRQ_MASK;
  wire wr_go = do_write && aw_q == REG_CMD_GO && w_q[0 +: 3] != OP_NONE;
  wire go_ok = wr_go && state == ST_IDLE;
  wire [7:0] rie_bits = {4'h0, cfg[CFG_RIE_BIT], 3'h0};
  wire stall_done = state == ST_WAIT && !io.cpu_stall;
  // Poll the strobe (and self-programming for writes) before an EE read or write; raw commands skip it
  wire hold_step = (op == OP_EE_WR || op == OP_EE_RD) && step == 3'h0
      && (io.io_rdata[CTRL_STROBE_BIT]
      || (op == OP_EE_WR && cfg[CFG_SELFPROG_BIT]));
  wire cmd_end = stall_done && plan_last && !hold_step;
  wire [2:0] irq_set = {wr_go && !go_ok, io.ready_irq && !ready_seen,
                        cmd_end};
  wire [2:0] irq_clr = (do_write && aw_q == REG_IRQ_STATUS && wstrb[0])
      ? w_q[2:0] : 3'h0;
  wire [2:0] next_status = irq_set | (irq_status & ~irq_clr);
  wire [31:0] read_mux = (araddr == REG_CMD_ADDR) ? 32'(cmd_addr)
      : (araddr == REG_CMD_DATA) ? 32'(cmd_data)
      : (araddr == REG_CMD_GO) ? 32'(state != ST_IDLE)
      : (araddr == REG_RESULT) ? 32'(result)
      : (araddr == REG_CONFIG) ? 32'(cfg)
      : (araddr == REG_IRQ_STATUS) ? 32'(irq_status)
      : (araddr == REG_IRQ_MASK) ? 32'(irq_mask)
      : 32'h0000_0000;
  wire hit_r = araddr == REG_CMD_ADDR || araddr == REG_CMD_DATA
      || araddr == REG_CMD_GO || araddr == REG_RESULT
      || araddr == REG_CONFIG || araddr == REG_IRQ_STATUS
      || araddr == REG_IRQ_MASK;

  // One io access per step of the current command
  always_comb begin
    plan_addr = OFS_CTRL;
    plan_wdata = 8'h00;
    plan_rd = 1'b1;
    plan_last = 1'b0;
    unique case (op)
      OP_RAW_WR: begin
        plan_addr = cmd_addr[5:0];
        plan_wdata = cmd_data;
        plan_rd = 1'b0;
        plan_last = 1'b1;
      end
      OP_RAW_RD: begin
        plan_addr = cmd_addr[5:0];
        plan_last = 1'b1;
      end
      OP_EE_WR, OP_EE_RD: begin
        plan_rd = step != 3'h0 && !(op == OP_EE_RD && step == 3'h4);
        plan_rd = !plan_rd;
        if (step == 3'h1) begin
          plan_addr = OFS_ADDR_HIGH;
          plan_wdata = {5'h00, cmd_addr[ADDR_W-1:8]};
        end else if (step == 3'h2) begin
          plan_addr = OFS_ADDR_LOW;
          plan_wdata = cmd_addr[7:0];
        end else if (step == 3'h3 && op == OP_EE_WR) begin
          plan_addr = OFS_DATA;
          plan_wdata = cmd_data;
        end else if (step == 3'h3) begin
          plan_wdata = rie_bits | 8'h01;
        end else if (step == 3'h4 && op == OP_EE_RD) begin
          plan_addr = OFS_DATA;
          plan_last = 1'b1;
        end else if (step == 3'h4) begin
          plan_wdata = rie_bits | 8'h04;
        end else if (step == 3'h5) begin
          plan_wdata = rie_bits | 8'h06;
          plan_last = 1'b1;
        end
      end
      default: begin
        plan_last = 1'b1;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= ST_IDLE;
      op <= OP_NONE;
      step <= 3'h0;
      result <= 8'h00;
      io.io_addr <= 6'h00;
      io.io_wdata <= 8'h00;
      io.io_wr <= 1'b0;
      io.io_rd <= 1'b0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (go_ok) begin
            op <= host_op_t'(w_q[2:0]);
            step <= 3'h0;
            state <= ST_PLAN;
          end
        end
        ST_PLAN: begin
          io.io_addr <= plan_addr;
          io.io_wdata <= plan_wdata;
          io.io_wr <= !plan_rd;
          io.io_rd <= plan_rd;
          state <= ST_ISSUE;
        end
        ST_ISSUE: begin
          io.io_wr <= 1'b0;
          io.io_rd <= 1'b0;
          state <= ST_WAIT;
        end
        ST_WAIT: begin
          if (stall_done) begin
            if (plan_rd) begin
              result <= io.io_rdata;
            end
            if (hold_step) begin
              state <= ST_PLAN;
            end else if (plan_last) begin
              state <= ST_IDLE;
            end else begin
              step <= step + 3'h1;
              state <= ST_PLAN;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmd_addr <= '0;
      cmd_data <= 8'h00;
      cfg <= 3'h0;
      irq_mask <= 3'h0;
      irq_status <= 3'h0;
      ready_seen <= 1'b0;
      irq <= 1'b0;
      io.global_irq_enable <= 1'b0;
      io.selfprog_busy <= 1'b0;
    end else begin
      if (do_write && wstrb[0]) begin
        if (aw_q == REG_CMD_ADDR) begin
          cmd_addr <= w_q[ADDR_W-1:0];
        end
        if (aw_q == REG_CMD_DATA) begin
          cmd_data <= w_q[7:0];
        end
        if (aw_q == REG_CONFIG) begin
          cfg <= w_q[2:0];
        end
        if (aw_q == REG_IRQ_MASK) begin
          irq_mask <= w_q[2:0];
        end
      end
      irq_status <= next_status;
      ready_seen <= io.ready_irq;
      irq <= |(next_status & irq_mask);
      // Interrupts stay off while any command sequence runs
      io.global_irq_enable <= cfg[CFG_GIE_BIT] && state == ST_IDLE
                              && !go_ok;
      io.selfprog_busy <= cfg[CFG_SELFPROG_BIT];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      wready <= 1'b1;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_q <= 8'h00;
      w_q <= 32'h0000_0000;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_q <= awaddr;
        aw_held <= 1'b1;
        awready <= 1'b0;
      end
      if (wvalid && wready) begin
        w_q <= wdata;
        w_held <= 1'b1;
        wready <= 1'b0;
      end
      if (do_write) begin
        bvalid <= 1'b1;
        bresp <= hit_w ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
        aw_held <= 1'b0;
        w_held <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= read_mux;
      rresp <= hit_r ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end
endmodule
`default_nettype wire

/* File: logic/nv_pkg.sv */
/*
  Shared constants for the data-EEPROM access block: I/O offsets, control
  bit positions, timing counts, and the host controller's register map.
  Assumes a single 100 MHz clock shared by both ends.
*/
package nv_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int RC_PERIOD_NS = 125;
  localparam int OSC_TICK_DIV = RC_PERIOD_NS / CLK_PERIOD_NS;
  localparam int WRITE_OSC_CYCLES = 27072;
  localparam int WRITE_TIME_US = 3400;

  localparam int ADDR_W = 11;
  localparam int MEM_BYTES = 2048;
  localparam int IO_ADDR_W = 6;

  localparam logic [5:0] OFS_CTRL = 6'h1F;
  localparam logic [5:0] OFS_DATA = 6'h20;
  localparam logic [5:0] OFS_ADDR_LOW = 6'h21;
  localparam logic [5:0] OFS_ADDR_HIGH = 6'h22;

  localparam int CTRL_READ_BIT = 0;
  localparam int CTRL_STROBE_BIT = 1;
  localparam int CTRL_ARM_BIT = 2;
  localparam int CTRL_RIE_BIT = 3;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  localparam logic [2:0] ARM_WINDOW = 3'h4;
  localparam logic [2:0] WRITE_STALL = 3'h2;
  localparam logic [2:0] READ_STALL = 3'h4;

  localparam int AXI_ADDR_W = 8;
  localparam logic [7:0] REG_CMD_ADDR = 8'h00;
  localparam logic [7:0] REG_CMD_DATA = 8'h04;
  localparam logic [7:0] REG_CMD_GO = 8'h08;
  localparam logic [7:0] REG_RESULT = 8'h0C;
  localparam logic [7:0] REG_CONFIG = 8'h10;
  localparam logic [7:0] REG_IRQ_STATUS = 8'h14;
  localparam logic [7:0] REG_IRQ_MASK = 8'h18;
  localparam int CFG_GIE_BIT = 0;
  localparam int CFG_RIE_BIT = 1;
  localparam int CFG_SELFPROG_BIT = 2;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_READY_BIT = 1;
  localparam int IRQ_REFUSED_BIT = 2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_RAW_WR = 3'b001,
    OP_RAW_RD = 3'b010,
    OP_EE_WR = 3'b011,
    OP_EE_RD = 3'b100
  } host_op_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PLAN = 2'b01,
    ST_ISSUE = 2'b10,
    ST_WAIT = 2'b11
  } host_state_t;
endpackage

/* File: logic/nv_io_if.sv */
/*
  I/O register bus between the CPU-side controller and the EEPROM device.
  Assumes both ends run on the same clock; strobes are one-cycle pulses.
*/
`timescale 1ns/10ps
`default_nettype none
interface nv_io_if;
  logic [5:0] io_addr;
  logic io_wr;
  logic io_rd;
  logic [7:0] io_wdata;
  logic [7:0] io_rdata;
  logic cpu_stall;
  logic global_irq_enable;
  logic selfprog_busy;
  logic ready_irq;

  modport device (
    input io_addr, io_wr, io_rd, io_wdata, global_irq_enable, selfprog_busy,
    output io_rdata, cpu_stall, ready_irq
  );
  modport cpu (
    output io_addr, io_wr, io_rd, io_wdata, global_irq_enable, selfprog_busy,
    input io_rdata, cpu_stall, ready_irq
  );
endinterface
`default_nettype wire

/* File: logic/nv_write_timer.sv */
/*
  Self-timing for one EEPROM write: divides the clock down to the RC
  oscillator rate and counts oscillator cycles. Assumes run stays high
  from start until done has been seen; reset only by supply loss.
*/
`timescale 1ns/10ps
`default_nettype none
module nv_write_timer
  import nv_pkg::*;
#(
  parameter int OSC_CYCLES = WRITE_OSC_CYCLES,
  parameter int TICK_DIV = OSC_TICK_DIV
) (
  input wire logic aclk,
  input wire logic supply_resetn,
  input wire logic run,
  output logic done
);
  localparam int DW = $clog2(TICK_DIV + 1);
  localparam int CW = $clog2(OSC_CYCLES + 1);

  logic [DW-1:0] div_cnt;
  logic [CW-1:0] osc_cnt;

  wire osc_tick = div_cnt == DW'(TICK_DIV - 1);
  wire last_tick = osc_tick && (osc_cnt == CW'(OSC_CYCLES - 1));

  // Counting halts and clears between writes so each write is full length
  always_ff @(posedge aclk) begin
    if (!supply_resetn || !run) begin
      div_cnt <= '0;
      osc_cnt <= '0;
    end else begin
      div_cnt <= osc_tick ? '0 : div_cnt + 1'b1;
      if (osc_tick) begin
        osc_cnt <= osc_cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!supply_resetn) begin
      done <= 1'b0;
    end else begin
      done <= run && last_tick;
    end
  end
endmodule
`default_nettype wire

/* File: logic/nv_eeprom_device.sv */
/*
  Data EEPROM with its CPU access registers: address, data and control.
  Writes are armed, strobed and self-timed; reads complete at once.
  Assumes the CPU side honours cpu_stall and the interface protocol.
*/
`timescale 1ns/10ps
`default_nettype none
module nv_eeprom_device
  import nv_pkg::*;
#(
  parameter bit BIG_VARIANT = 1'b1,
  parameter int OSC_CYCLES = WRITE_OSC_CYCLES,
  parameter int TICK_DIV = OSC_TICK_DIV
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic supply_resetn,
  input wire logic powerdown_req,
  nv_io_if.device io,
  output logic write_busy,
  output logic deep_powerdown
);
  logic [7:0] mem [0:MEM_BYTES-1];
  logic [ADDR_W-1:0] nv_byte_pointer;
  logic [7:0] nv_data_byte;
  logic nv_ready_irq_enable;
  logic [2:0] arm_left;
  logic [2:0] stall_left;
  logic busy;
  logic osc_hold;
  logic [ADDR_W-1:0] wr_ptr;
  logic [7:0] wr_byte;
  logic timer_done;

  wire sel_low = io.io_addr == OFS_ADDR_LOW;
  wire sel_high = io.io_addr == OFS_ADDR_HIGH;
  wire sel_data = io.io_addr == OFS_DATA;
  wire sel_ctrl = io.io_addr == OFS_CTRL;
  wire wr_low = io.io_wr && sel_low;
  wire wr_high = io.io_wr && sel_high;
  wire wr_data = io.io_wr && sel_data;
  wire wr_ctrl = io.io_wr && sel_ctrl;

  wire nv_write_arm = arm_left != 3'h0;
  wire set_arm = wr_ctrl && io.io_wdata[CTRL_ARM_BIT];
  wire strobe_req = wr_ctrl && io.io_wdata[CTRL_STROBE_BIT];
  // A strobe outside the arm window, during a write, or while flash
  // self-programming runs is simply dropped
  wire start_write = strobe_req && nv_write_arm && !busy
                     && !io.selfprog_busy;
  wire start_read = wr_ctrl && io.io_wdata[CTRL_READ_BIT] && !busy;
  wire ptr_open = !busy;

  // The small part ignores the top address bit for memory access; the address register still holds it
  wire [ADDR_W-1:0] mem_idx = BIG_VARIANT ? nv_byte_pointer
      : {1'b0, nv_byte_pointer[ADDR_W-2:0]};

  wire [7:0] high_view = {5'h00, nv_byte_pointer[ADDR_W-1:8]};
  wire [7:0] ctrl_view = {4'h0, nv_ready_irq_enable, nv_write_arm, busy,
                          1'b0};
  wire [7:0] read_mux = sel_low ? nv_byte_pointer[7:0]
                      : sel_high ? high_view
                      : sel_data ? nv_data_byte
                      : sel_ctrl ? ctrl_view
                      : 8'h00;

  wire next_busy = start_write || (busy && !timer_done);
  wire next_rie = wr_ctrl ? io.io_wdata[CTRL_RIE_BIT] : nv_ready_irq_enable;
  wire [2:0] stall_dec = (stall_left == 3'h0) ? 3'h0 : stall_left - 3'h1;
  wire [2:0] next_stall = start_write ? WRITE_STALL
                        : start_read ? READ_STALL
                        : stall_dec;
  wire next_osc_hold = powerdown_req && (osc_hold || busy);

  nv_write_timer #(
    .OSC_CYCLES(OSC_CYCLES),
    .TICK_DIV(TICK_DIV)
  ) u_timer (
    .aclk(aclk),
    .supply_resetn(supply_resetn),
    .run(busy),
    .done(timer_done)
  );

  // Address is deliberately left without reset; software loads it first
  always_ff @(posedge aclk) begin
    if (ptr_open) begin
      if (wr_low) begin
        nv_byte_pointer[7:0] <= io.io_wdata;
      end
      if (wr_high) begin
        nv_byte_pointer[ADDR_W-1:8] <= io.io_wdata[ADDR_W-9:0];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      nv_data_byte <= 8'h00;
    end else if (start_read) begin
      nv_data_byte <= mem[mem_idx];
    end else if (wr_data) begin
      nv_data_byte <= io.io_wdata;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      nv_ready_irq_enable <= CTRL_RESET[CTRL_RIE_BIT];
      arm_left <= 3'h0;
      stall_left <= 3'h0;
      io.cpu_stall <= 1'b0;
      io.io_rdata <= 8'h00;
      io.ready_irq <= 1'b0;
    end else begin
      nv_ready_irq_enable <= next_rie;
      if (set_arm) begin
        arm_left <= ARM_WINDOW;
      end else if (nv_write_arm) begin
        arm_left <= arm_left - 3'h1;
      end
      stall_left <= next_stall;
      io.cpu_stall <= next_stall != 3'h0;
      if (io.io_rd) begin
        io.io_rdata <= read_mux;
      end
      // Level request; falls in the strobe cycle, rises when write ends
      io.ready_irq <= next_rie && io.global_irq_enable
                      && !next_busy;
    end
  end

  // The write engine answers only to supply loss, so an ordinary reset
  // in mid-write lets the byte finish
  always_ff @(posedge aclk) begin
    if (!supply_resetn) begin
      busy <= 1'b0;
      wr_ptr <= '0;
      wr_byte <= 8'h00;
    end else begin
      busy <= next_busy;
      if (start_write) begin
        wr_ptr <= mem_idx;
        wr_byte <= nv_data_byte;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (busy && timer_done) begin
      mem[wr_ptr] <= wr_byte;
    end
  end

  // The timing oscillator stays on after a write finished in sleep, so
  // full power-down waits until the sleep request is withdrawn
  always_ff @(posedge aclk) begin
    if (!supply_resetn) begin
      osc_hold <= 1'b0;
      deep_powerdown <= 1'b0;
      write_busy <= 1'b0;
    end else begin
      osc_hold <= next_osc_hold;
      deep_powerdown <= powerdown_req && !next_osc_hold;
      write_busy <= next_busy;
    end
  end
endmodule
`default_nettype wire

/* File: verification/nv_io_sva.sv */
/*
  Assertions on the EEPROM I/O bus between host controller and device.
  Assumes one clock, a synchronous active-low reset, and instantiation
  beside the interface instance in the bench top.
*/
`timescale 1ns/10ps
`default_nettype none
module nv_io_sva
  import nv_pkg::*;
#(
  parameter int OSC_CYCLES = WRITE_OSC_CYCLES,
  parameter int TICK_DIV = OSC_TICK_DIV
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [5:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata,
  input wire logic cpu_stall,
  input wire logic global_irq_enable,
  input wire logic selfprog_busy,
  input wire logic ready_irq,
  input wire logic write_busy
);
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  localparam int WLEN = OSC_CYCLES * TICK_DIV;
  wire ctrl_wr = io_wr && io_addr == OFS_CTRL;
  wire arm_wr = ctrl_wr && io_wdata[CTRL_ARM_BIT];
  wire read_req = ctrl_wr && io_wdata[CTRL_READ_BIT];
  logic [2:0] arm_age;
  logic rie_copy;
  logic [15:0] busy_len;
  wire [2:0] next_arm_age = arm_wr ? 3'h1 : arm_age + {2'h0, arm_age != 3'h7};
  wire next_rie = ctrl_wr ? io_wdata[CTRL_RIE_BIT] : rie_copy;
  // A write survives the bus reset, so its length counter ignores it
  always_ff @(posedge aclk) begin
    busy_len <= write_busy ? busy_len + 16'h0001 : 16'h0000;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arm_age <= 3'h7;
      rie_copy <= 1'b0;
    end else begin
      arm_age <= next_arm_age;
      rie_copy <= next_rie;
    end
  end
  a_write_stall_two: assert property ($rose(write_busy) |->
    cpu_stall ##1 cpu_stall ##1 !cpu_stall) else $error("write stall wrong");
  a_read_stall_four: assert property (read_req && !write_busy |=>
    cpu_stall [*4] ##1 !cpu_stall) else $error("read stall wrong");
  a_busy_read_refused: assert property (
    read_req && write_busy && !cpu_stall |=> !cpu_stall)
    else $error("read taken during write");
  a_write_cause: assert property ($rose(write_busy) |->
    $past(ctrl_wr && io_wdata[CTRL_STROBE_BIT] && !selfprog_busy))
    else $error("write started without strobe");
  a_arm_window: assert property ($rose(write_busy) |->
    $past(arm_age) >= 3'h1 && $past(arm_age) <= 3'h4)
    else $error("write started outside arm window");
  // Enable and busy are latched on the same edge as the request itself
  a_ready_tracks: assert property (ready_irq ==
    (rie_copy && $past(global_irq_enable) && !write_busy))
    else $error("ready request wrong");
  a_ready_drops: assert property ($rose(write_busy) |-> !ready_irq)
    else $error("ready request high at write start");
  a_rdata_holds: assert property (!io_rd |=> $stable(io_rdata))
    else $error("read byte changed without read");
  a_write_length: assert property ($fell(write_busy) |->
    busy_len >= WLEN && busy_len <= WLEN + 4) else $error("write length wrong");
  cover property ($rose(write_busy));
  cover property (read_req && write_busy);
  cover property ($rose(ready_irq));
endmodule
`default_nettype wire

/* File: verification/tb_top.sv */
/*
  Bench: host controller and EEPROM device joined by the I/O interface,
  driven over AXI4-Lite. Assumes a shortened write time on the device.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import nv_pkg::*;
;
  localparam int WOSC = 200;
  localparam int WDIV = 2;
  logic aclk = 1'b0;
  logic aresetn, supply_resetn, powerdown_req, irq, write_busy;
  logic awvalid, awready, wvalid, wready, bvalid, bready, deep_powerdown;
  logic arvalid, arready, rvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rv;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rs;
  int mismatches = 0;
  int samples_checked = 0;
  int cycles = 0;
  logic [10:0] addr_tab [3] = '{11'h000, 11'h3FF, 11'h7FF};
  logic [7:0] data_tab [3] = '{8'hC3, 8'h5A, 8'hA5};
  nv_io_if io_bus();
  nv_host_ctrl u_nv_host_ctrl (.aclk, .aresetn, .awaddr, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
    .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .irq, .io(io_bus));
  nv_eeprom_device #(.BIG_VARIANT(1'b1), .OSC_CYCLES(WOSC), .TICK_DIV(WDIV))
    u_nv_eeprom_device (.aclk, .aresetn, .supply_resetn, .powerdown_req,
    .io(io_bus), .write_busy, .deep_powerdown);
  nv_io_sva #(.OSC_CYCLES(WOSC), .TICK_DIV(WDIV)) u_nv_io_sva (.aclk,
    .aresetn, .io_addr(io_bus.io_addr), .io_wr(io_bus.io_wr),
    .io_rd(io_bus.io_rd), .io_wdata(io_bus.io_wdata),
    .io_rdata(io_bus.io_rdata), .cpu_stall(io_bus.cpu_stall),
    .global_irq_enable(io_bus.global_irq_enable),
    .selfprog_busy(io_bus.selfprog_busy), .ready_irq(io_bus.ready_irq),
    .write_busy);
  always #5 aclk = ~aclk;
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge aclk) begin
    cycles++;
    if (cycles > 60000) begin
      mismatches++;
      conclude();
    end
  end
  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    rs = bresp;
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rv = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask
  task automatic cmd(input host_op_t op, input logic [10:0] a,
                     input logic [7:0] d);
    axi_wr(REG_CMD_ADDR, {21'h0_0000, a});
    axi_wr(REG_CMD_DATA, {24'h00_0000, d});
    axi_wr(REG_CMD_GO, {29'h0000_0000, op});
    do axi_rd(REG_CMD_GO); while (rv[0] !== 1'b0);
  endtask
  task automatic raw_wr(input logic [5:0] ofs, input logic [7:0] d);
    cmd(OP_RAW_WR, {5'h00, ofs}, d);
  endtask
  task automatic raw_chk(input string what, input logic [5:0] ofs,
                         input logic [7:0] exp);
    cmd(OP_RAW_RD, {5'h00, ofs}, 8'h00);
    axi_rd(REG_RESULT);
    check(what, 32'(exp), rv);
  endtask
  task automatic ee_chk(input string what, input logic [10:0] a,
                        input logic [7:0] exp);
    cmd(OP_EE_RD, a, 8'h00);
    axi_rd(REG_RESULT);
    check(what, 32'(exp), rv);
  endtask
  initial begin
    {aresetn, supply_resetn, powerdown_req, awvalid, wvalid, bready} = '0;
    {arvalid, rready, awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    supply_resetn <= 1'b1;
    axi_rd(8'h1C);
    check("unmapped resp", 32'(RESP_SLVERR), 32'(rs));
    axi_wr(8'h1C, 32'h0000_0000);
    check("unmapped bresp", 32'(RESP_SLVERR), 32'(rs));
    raw_chk("ctrl reset", OFS_CTRL, CTRL_RESET);
    raw_wr(OFS_ADDR_HIGH, 8'hFF);
    raw_chk("addr high", OFS_ADDR_HIGH, 8'h07);
    $display("test registers done");
    axi_wr(REG_CONFIG, 32'h0000_0003);
    check("config bresp", 32'(RESP_OKAY), 32'(rs));
    for (int i = 0; i < 3; i++) cmd(OP_EE_WR, addr_tab[i], data_tab[i]);
    for (int i = 0; i < 3; i++) ee_chk("ee byte", addr_tab[i], data_tab[i]);
    axi_rd(REG_IRQ_STATUS);
    check("ready event", 32'h0000_0001, 32'(rv[IRQ_READY_BIT]));
    check("masked irq", 32'h0000_0000, 32'(irq));
    $display("test write read done");
    raw_wr(OFS_DATA, 8'h3C);
    raw_wr(OFS_CTRL, 8'h02);
    raw_chk("unarmed", OFS_CTRL, 8'h00);
    raw_wr(OFS_CTRL, 8'h04);
    raw_chk("arm expired", OFS_CTRL, 8'h00);
    raw_wr(OFS_CTRL, 8'h02);
    ee_chk("no write", 11'h7FF, 8'hA5);
    $display("test refusals done");
    cmd(OP_EE_WR, 11'h020, 8'h77);
    raw_wr(OFS_ADDR_LOW, 8'h55);
    raw_chk("addr frozen", OFS_ADDR_LOW, 8'h20);
    raw_wr(OFS_CTRL, 8'h09);
    raw_chk("ctrl busy", OFS_CTRL, 8'h0A);
    ee_chk("busy write", 11'h020, 8'h77);
    $display("test busy done");
    axi_wr(REG_IRQ_MASK, 32'h0000_0004);
    axi_wr(REG_CONFIG, 32'h0000_0007);
    axi_wr(REG_CMD_GO, 32'h0000_0003);
    axi_wr(REG_CMD_GO, 32'h0000_0003);
    axi_rd(REG_CMD_GO);
    check("selfprog wait", 32'h0000_0001, 32'(rv[0]));
    check("refused irq", 32'h0000_0001, 32'(irq));
    axi_wr(REG_IRQ_STATUS, 32'h0000_0004);
    check("irq cleared", 32'h0000_0000, 32'(irq));
    axi_wr(REG_CONFIG, 32'h0000_0003);
    do axi_rd(REG_CMD_GO); while (rv[0] !== 1'b0);
    ee_chk("after selfprog", 11'h020, 8'h00);
    $display("test selfprog done");
    cmd(OP_EE_WR, 11'h030, 8'h99);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    check("busy in reset", 32'h0000_0001, 32'(write_busy));
    ee_chk("after reset", 11'h030, 8'h99);
    $display("test reset done");
    cmd(OP_EE_WR, 11'h031, 8'h42);
    powerdown_req <= 1'b1;
    while (write_busy !== 1'b0) @(posedge aclk);
    repeat (4) @(posedge aclk);
    check("sleep blocked", 32'h0000_0000, 32'(deep_powerdown));
    powerdown_req <= 1'b0;
    repeat (2) @(posedge aclk);
    powerdown_req <= 1'b1;
    repeat (4) @(posedge aclk);
    check("sleep idle", 32'h0000_0001, 32'(deep_powerdown));
    powerdown_req <= 1'b0;
    ee_chk("sleep write", 11'h031, 8'h42);
    $display("test sleep done");
    conclude();
  end
endmodule
`default_nettype wire
